// ==== src/pwm_shadow_update_mode.sv ====
// Purpose: update-mode control for dead-band and generator-b registers
// Assumes: counter zero and sync request come from logic on clk_sys
// Notes: mode value 1 behaves like a write that never applies
//
// Behaviour
// - Dead-band update mode is a r/w field at bits 11:10, reset 0.
// - Generator-b update mode is a r/w field at bits 9:8, reset 0.
// - Mode 0 makes a dead-band write active at once.
// - Mode 0 makes a generator-b write active at once.
// - Mode 2 applies the pending value at the next counter zero.
// - Mode 3 applies it at the first counter zero after a sync request.
`timescale 1ns/1ps
`include "pwm_shadow_cfg.svh"
module pwm_shadow_update_mode (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic ctl_wr,
   input wire logic [`REG_W-1:0] ctl_wdata,
   output logic [`REG_W-1:0] ctl_rdata,
   input wire logic db_wr,
   input wire logic gb_wr,
   input wire logic [`REG_W-1:0] reg_wdata,
   input wire logic cnt_zero,
   input wire logic sync_req,
   output logic [`REG_W-1:0] db_active,
   output logic [`REG_W-1:0] gb_active,
   output logic db_pending,
   output logic gb_pending
);
   // ==========================================================
   // reset release
   // ==========================================================
   logic [1:0] rst_sync_ff;
   logic rst_n;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ==========================================================
   // control state
   // ==========================================================
   typedef struct packed {
      logic [1:0] db_mode;
      logic [1:0] gb_mode;
      logic armed;
   } ctl_state_t;
   ctl_state_t st_ff;
   ctl_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (ctl_wr) begin
         nxt_st.db_mode = ctl_wdata[`DB_MODE_HI:`DB_MODE_LO];
         nxt_st.gb_mode = ctl_wdata[`GB_MODE_HI:`GB_MODE_LO];
      end
      // request stays armed until a zero consumes it; set wins
      if (cnt_zero) begin
         nxt_st.armed = 1'b0;
      end
      if (sync_req) begin
         nxt_st.armed = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{`MODE_RST, `MODE_RST, 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      ctl_rdata = '0;
      ctl_rdata[`DB_MODE_HI:`DB_MODE_LO] = st_ff.db_mode;
      ctl_rdata[`GB_MODE_HI:`GB_MODE_LO] = st_ff.gb_mode;
   end

   // ==========================================================
   // shadow slots
   // ==========================================================
   logic [1:0] slot_mode [2];
   logic slot_wr [2];
   logic [`REG_W-1:0] slot_active [2];
   logic slot_pending [2];

   assign slot_mode[0] = st_ff.db_mode;
   assign slot_mode[1] = st_ff.gb_mode;
   assign slot_wr[0] = db_wr;
   assign slot_wr[1] = gb_wr;

   // slot 0 is the dead-band register, slot 1 the generator-b one
   for (genvar i = 0; i < 2; i++) begin : g_slot
      shadow_if slot_if ();
      assign slot_if.mode = slot_mode[i];
      assign slot_if.wr = slot_wr[i];
      assign slot_if.wdata = reg_wdata;
      assign slot_if.zero = cnt_zero;
      assign slot_if.sync_armed = st_ff.armed;
      shadow_slot u_slot (
         .clk_sys(clk_sys),
         .reset_n(rst_n),
         .s(slot_if)
      );
      assign slot_active[i] = slot_if.active;
      assign slot_pending[i] = slot_if.pending;
   end

   assign db_active = slot_active[0];
   assign gb_active = slot_active[1];
   assign db_pending = slot_pending[0];
   assign gb_pending = slot_pending[1];
endmodule

// ==== src/pwm_shadow_cfg.svh ====
// Purpose: constants for the pwm shadow update block
// Assumes: generator control word holds the update-mode fields
// Notes: widths of the shadowed registers are fixed at 32 bits
`ifndef PWM_SHADOW_CFG_SVH
`define PWM_SHADOW_CFG_SVH
`define DB_MODE_HI 11
`define DB_MODE_LO 10
`define GB_MODE_HI 9
`define GB_MODE_LO 8
`define MODE_RST 2'h0
`define REG_W 32
`define REG_RST 32'h0000_0000
`endif

// ==== src/pwm_shadow_pkg.sv ====
// Purpose: types for the pwm shadow update block
// Assumes: nothing
// Notes: mode codes follow the field encoding
`include "pwm_shadow_cfg.svh"
package pwm_shadow_pkg;
   typedef enum logic [1:0] {
      MODE_IMMEDIATE = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_LOCAL = 2'h2,
      MODE_GLOBAL = 2'h3
   } upd_mode_t;
endpackage

// ==== src/shadow_if.sv ====
// Purpose: carrier between the top and a shadow slot
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`include "pwm_shadow_cfg.svh"
interface shadow_if;
   logic [1:0] mode;
   logic wr;
   logic [`REG_W-1:0] wdata;
   logic zero;
   logic sync_armed;
   logic [`REG_W-1:0] active;
   logic pending;
   modport top (output mode, wr, wdata, zero, sync_armed,
                input active, pending);
   modport slot (input mode, wr, wdata, zero, sync_armed,
                 output active, pending);
endinterface

// ==== src/shadow_slot.sv ====
// Purpose: one shadowed register with its update-mode handling
// Assumes: reset_n is already synchronised
// Notes: a pending value waits for the event chosen by mode
`timescale 1ns/1ps
`include "pwm_shadow_cfg.svh"
module shadow_slot (
   input wire logic clk_sys,
   input wire logic reset_n,
   shadow_if.slot s
);
   typedef struct packed {
      logic [`REG_W-1:0] active;
      logic [`REG_W-1:0] shadow;
      logic pending;
   } slot_state_t;
   slot_state_t st_ff;
   slot_state_t nxt_st;
   logic fire;

   always_comb begin
      nxt_st = st_ff;
      fire = 1'b0;
      case (pwm_shadow_pkg::upd_mode_t'(s.mode))
         pwm_shadow_pkg::MODE_LOCAL: fire = s.zero;
         pwm_shadow_pkg::MODE_GLOBAL: fire = s.zero & s.sync_armed;
         default: fire = 1'b0;
      endcase
      if (st_ff.pending && fire) begin
         nxt_st.active = st_ff.shadow;
         nxt_st.pending = 1'b0;
      end
      if (s.wr) begin
         if (s.mode == 2'h0) begin
            // immediate write also drops any stale pending value
            nxt_st.active = s.wdata;
            nxt_st.pending = 1'b0;
         end else begin
            // a write at the firing edge queues behind the applied value
            nxt_st.shadow = s.wdata;
            nxt_st.pending = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '{`REG_RST, `REG_RST, 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s.active = st_ff.active;
   assign s.pending = st_ff.pending;
endmodule

// ==== verification/pwm_shadow_asserts.sv ====
// Purpose: checker for the shadow update modes
// Assumes: bound to pwm_shadow_update_mode
// Notes: sequences pin down the cycle of each apply
`timescale 1ns/1ps
`include "pwm_shadow_cfg.svh"
module pwm_shadow_asserts (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic ctl_wr,
   input wire logic [`REG_W-1:0] ctl_wdata,
   input wire logic [`REG_W-1:0] ctl_rdata,
   input wire logic db_wr,
   input wire logic gb_wr,
   input wire logic [`REG_W-1:0] reg_wdata,
   input wire logic cnt_zero,
   input wire logic sync_req,
   input wire logic [`REG_W-1:0] db_active,
   input wire logic [`REG_W-1:0] gb_active,
   input wire logic db_pending,
   input wire logic gb_pending
);
   logic [1:0] dbm;
   logic [1:0] gbm;
   assign dbm = ctl_rdata[11:10];
   assign gbm = ctl_rdata[9:8];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_db_mode_rw: assert property (
      ctl_wr |=> dbm == $past(ctl_wdata[11:10])) else $error("db mode");
   a_gb_mode_rw: assert property (
      ctl_wr |=> gbm == $past(ctl_wdata[9:8])) else $error("gb mode");
   a_db_write_now: assert property (
      db_wr && dbm == 2'h0 |=>
      db_active == $past(reg_wdata)) else $error("db now");
   a_gb_write_now: assert property (
      gb_wr && gbm == 2'h0 |=>
      gb_active == $past(reg_wdata)) else $error("gb now");
   a_db_zero_apply: assert property (
      (db_wr && dbm == 2'h2 && !ctl_wr) ##1
      (cnt_zero && !db_wr && !ctl_wr) |=>
      db_active == $past(reg_wdata, 2) && !db_pending) else $error("local");
   a_gb_zero_apply: assert property (
      (gb_wr && gbm == 2'h2 && !ctl_wr) ##1
      (cnt_zero && !gb_wr && !ctl_wr) |=>
      gb_active == $past(reg_wdata, 2) && !gb_pending)
      else $error("gb local");
   a_db_sync_wait: assert property (
      (cnt_zero && !sync_req) ##1
      (db_wr && dbm == 2'h3 && !sync_req && !cnt_zero && !ctl_wr) ##1
      (cnt_zero && !sync_req && !db_wr && !ctl_wr) |=>
      db_pending) else $error("global");
   a_db_sync_apply: assert property (
      (db_wr && dbm == 2'h3 && !ctl_wr) ##1
      (sync_req && !cnt_zero && !db_wr && !ctl_wr) ##1
      (cnt_zero && !db_wr && !ctl_wr) |=>
      db_active == $past(reg_wdata, 3) && !db_pending)
      else $error("sync apply");
   a_db_last_wins: assert property (
      (db_wr && dbm == 2'h2 && !ctl_wr) ##1
      (db_wr && !ctl_wr) ##1 (cnt_zero && !db_wr && !ctl_wr) |=>
      db_active == $past(reg_wdata, 2)) else $error("last write");
endmodule
bind pwm_shadow_update_mode pwm_shadow_asserts u_chk (.*);

// ==== verification/pwm_shadow_update_mode_tb.sv ====
// Purpose: random traffic against a cycle model of both slots
// Assumes: modes come from the field encoding
// Notes: the reserved mode is never written
`timescale 1ns/1ps
`include "pwm_shadow_cfg.svh"
module pwm_shadow_update_mode_tb;
   logic clk_sys = 0, reset_n = 0, ctl_wr = 0, db_wr = 0, gb_wr = 0;
   logic cnt_zero = 0, sync_req = 0, db_pending, gb_pending;
   logic [`REG_W-1:0] ctl_wdata = '0, reg_wdata = '0, ctl_rdata;
   logic [`REG_W-1:0] db_active, gb_active, lf = 32'h40697E56;
   logic [`REG_W-1:0] act [2] = '{0, 0}, pv [2];
   logic [1:0] m [2] = '{0, 0};
   bit pend [2], armed;
   int error_cnt, compares;
   pwm_shadow_update_mode dut (.*);
   initial forever #4 clk_sys = ~clk_sys;
   function logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========
   // model: apply first, then a write on top; old mode and armed used
   always @(posedge clk_sys) begin
      for (int i = 0; i < 2; i++) begin
         if (pend[i] && cnt_zero && (m[i] == 2'h2 ||
             m[i] == 2'h3 && armed)) begin
            act[i] = pv[i];
            pend[i] = 0;
         end
         if (i ? gb_wr : db_wr) begin
            pend[i] = m[i] != 2'h0;
            if (pend[i]) pv[i] = reg_wdata; else act[i] = reg_wdata;
         end
      end
      armed = sync_req | armed & !cnt_zero;
      if (ctl_wr) m = '{ctl_wdata[11:10], ctl_wdata[9:8]};
   end
   always @(negedge clk_sys) begin
      chk(db_active, act[0]);
      chk(gb_active, act[1]);
      chk({30'h0, db_pending, gb_pending},
          {30'h0, pend[0], pend[1]});
      chk(ctl_rdata, {20'h0, m[0], m[1], 8'h0});
   end
   // ==========
   // stimulus
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 reset_n = 1;
      repeat (3) @(posedge clk_sys);
      for (int t = 0; t < 3; t++) begin
         repeat (300) begin
            #1 lf = nx(lf);
            db_wr = lf[0] & lf[1];
            gb_wr = lf[2] & lf[3];
            cnt_zero = lf[4] & (lf[5] | t == 0);
            sync_req = &lf[8:6];
            ctl_wr = &lf[12:9];
            ctl_wdata = nx(~lf);
            ctl_wdata[11:10] = lf[13] ? {1'b1, lf[14]} : 2'h0;
            ctl_wdata[9:8] = lf[15] ? {1'b1, lf[16]} : 2'h0;
            reg_wdata = nx(lf ^ 32'h5A5A5A5A);
            @(posedge clk_sys);
         end
         $display("test %0d done", t);
      end
      stop_test;
   end
   initial begin
      #12000 error_cnt++;
      stop_test;
   end
endmodule
